// ---- rtl/sser_top.sv ----
`timescale 1ns/10ps
module sser_top import sser_pkg::*; #(
   parameter int unsigned TMR_WRAP = 32'(TMR_WRAP_CYC)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extWakeIn,
   input wire logic intWakeIn,
   input wire logic pcieWakeMsgIn,
   input wire logic hotPlugMsgIn,
   input wire logic buttonPressIn,
   input wire logic buttonOverrideIn,
   input wire logic processorSciIn,
   input wire logic wdSciEventIn,
   input wire logic wdSmiEventIn,
   input wire logic centuryRollIn,
   input wire logic wdTimeoutIn,
   input wire logic nmiIn,
   input wire logic chassisIntrusionIn,
   input wire logic fwWriteAttemptIn,
   input wire logic serialIrqSmiIn,
   input wire logic devTrapMatchIn,
   output logic smiMsgValid,
   input wire logic smiMsgReady,
   output logic sciOut,
   output logic [4:0] sciIrqNum
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NSRC-1:0] sts;
      logic [NSRC-1:0] en;
      logic sciEn;
      logic smiDone;
      logic apic;
      logic [2:0] irqSel;
      logic shared;
      logic [1:0] intrSel;
      logic lock;
      logic fw_write_protect_disable;
      logic [7:0] wdData;
      logic [7:0] pmPort;
      logic intrPrev;
      sser_vw_t vw;
      logic sciLvl;
      logic [4:0] irqNum;
      logic [31:0] tmr;
      logic [31:0] rdata;
   } sser_state_t;

   sser_state_t r;
   sser_state_t n;
   logic acc;
   logic wr;
   logic hit;
   logic [NSRC-1:0] ev;
   logic [NSRC-1:0] clr;
   logic [NSRC-1:0] effEn;
   logic sciAct;
   logic smiAct;
   logic tmrWrap;
   logic smiDoneSet;
   logic wpdNew;

   // ------------------------------------------------------------
   // bus decode: zero wait state, error on unmapped address
   // ------------------------------------------------------------
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign hit = (paddr == OFS_STATUS) || (paddr == OFS_ENABLE) || (paddr == OFS_CTRL)
      || (paddr == OFS_WD_DATA) || (paddr == OFS_PM_PORT);
   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   assign prdata = r.rdata;
   assign smiMsgValid = (r.vw == VW_SEND);
   assign sciOut = r.sciLvl;
   assign sciIrqNum = r.irqNum;

   // sources without an enable bit behave as permanently enabled
   assign effEn = r.en | MASK_FIXED_EN;
   assign tmrWrap = (r.tmr == TMR_WRAP - 1);
   assign smiDoneSet = wr && (paddr == OFS_CTRL) && pwdata[CTL_SMI_DONE];
   assign wpdNew = pwdata[CTL_WPD];

   // ------------------------------------------------------------
   // interrupt aggregation
   // ------------------------------------------------------------
   // global status reaches sci even with the global enable clear
   assign sciAct = r.sciEn
      ? |(r.sts & effEn & (MASK_SCI_ONLY | MASK_DUAL))
      : |(r.sts & effEn & MASK_GLOBAL);
   // dual sources go to smi only while the global enable is clear
   assign smiAct = |(r.sts & effEn & MASK_SMI_ONLY)
      || (!r.sciEn && |(r.sts & effEn & MASK_DUAL));

   // ------------------------------------------------------------
   // event vector
   // ------------------------------------------------------------
   always_comb begin
      ev = '0;
      ev[SRC_EXT_WAKE] = extWakeIn;
      ev[SRC_INT_WAKE] = intWakeIn;
      ev[SRC_PCIE_WAKE] = pcieWakeMsgIn;
      ev[SRC_HOT_PLUG] = hotPlugMsgIn;
      ev[SRC_BTN_PRESS] = buttonPressIn;
      ev[SRC_BTN_OVR] = buttonOverrideIn;
      ev[SRC_TMR_WRAP] = tmrWrap;
      ev[SRC_CPU_SCI] = processorSciIn;
      ev[SRC_WD_SCI] = wdSciEventIn;
      // a redirected nmi reports in both watchdog and nmi status
      ev[SRC_NMI] = nmiIn && r.en[SRC_NMI];
      ev[SRC_WD_SMI] = wdSmiEventIn || ev[SRC_NMI];
      ev[SRC_CENTURY] = centuryRollIn;
      ev[SRC_WD_TMO] = wdTimeoutIn;
      ev[SRC_OS_DATA] = wr && (paddr == OFS_WD_DATA);
      ev[SRC_INTRUDE] = chassisIntrusionIn && !r.intrPrev
         && (r.intrSel == INTR_SEL_SMI);
      // disable bit rising under lock, or a write while protected
      ev[SRC_FW_WRITE] = (wr && (paddr == OFS_CTRL) && wpdNew && !r.fw_write_protect_disable && r.lock)
         || (fwWriteAttemptIn && !r.fw_write_protect_disable);
      ev[SRC_GLOBAL] = wr && (paddr == OFS_CTRL) && pwdata[CTL_FW_REL];
      ev[SRC_FW_STS] = wr && (paddr == OFS_CTRL) && pwdata[CTL_GBL_REL];
      ev[SRC_PM_PORT] = wr && (paddr == OFS_PM_PORT);
      ev[SRC_SER_IRQ] = serialIrqSmiIn;
      ev[SRC_DEV_TRAP] = devTrapMatchIn;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      clr = '0;
      // register writes
      if (wr) begin
         case (paddr)
            OFS_STATUS: clr = pwdata[NSRC-1:0];
            OFS_ENABLE: n.en = pwdata[NSRC-1:0];
            OFS_CTRL: begin
               n.sciEn = pwdata[CTL_ACPI_INT_GLOBAL_ENABLE];
               n.apic = pwdata[CTL_APIC];
               n.irqSel = pwdata[CTL_IRQ_LSB +: 3];
               n.shared = pwdata[CTL_SHARED];
               n.intrSel = pwdata[CTL_INTR_LSB +: 2];
               n.lock = pwdata[CTL_LOCK];
               n.fw_write_protect_disable = wpdNew;
            end
            OFS_WD_DATA: n.wdData = pwdata[7:0];
            OFS_PM_PORT: n.pmPort = pwdata[7:0];
            default: n.en = r.en;
         endcase
      end
      // a new event beats a same-cycle clear
      n.sts = (r.sts & ~clr) | ev;
      n.intrPrev = chassisIntrusionIn;
      n.tmr = tmrWrap ? 32'h0 : r.tmr + 32'h1;
      // smi message sequencer; software set is seen before the hardware clear
      n.smiDone = r.smiDone || smiDoneSet;
      case (r.vw)
         VW_IDLE: begin
            if (n.smiDone && smiAct) begin
               n.smiDone = 1'b0;
               n.vw = VW_SEND;
            end
         end
         VW_SEND: begin
            if (smiMsgReady) begin
               n.vw = VW_IDLE;
            end
         end
         default: n.vw = VW_IDLE;
      endcase
      // shared pci lines are active low, private lines active high
      n.sciLvl = sciAct ^ r.shared;
      // legacy mode sends any choice above line 11 back to line 9
      if (!r.apic && (r.irqSel > IRQ_SEL_MAX_LEGACY)) begin
         n.irqNum = IRQ_BASE_LEGACY;
      end else if (r.irqSel > IRQ_SEL_MAX_LEGACY) begin
         n.irqNum = IRQ_BASE_APIC + {2'h0, r.irqSel};
      end else begin
         n.irqNum = IRQ_BASE_LEGACY + {2'h0, r.irqSel};
      end
      // read data captured in the setup phase
      if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_STATUS: n.rdata = {11'h0, r.sts};
            OFS_ENABLE: n.rdata = {11'h0, r.en};
            OFS_CTRL: n.rdata = {20'h0, r.fw_write_protect_disable, r.lock, r.intrSel, r.shared, r.irqSel,
               1'b0, r.apic, r.smiDone, r.sciEn};
            OFS_WD_DATA: n.rdata = {24'h0, r.wdData};
            OFS_PM_PORT: n.rdata = {24'h0, r.pmPort};
            default: n.rdata = 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.smiDone <= RST_SMI_DONE;
         r.vw <= VW_IDLE;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_doneWrite;
      smiDoneSet && r.vw == VW_IDLE && !r.smiDone && smiAct;
   endsequence

   sequence s_msgOut;
      smiMsgValid && !r.smiDone;
   endsequence

   property p_smiFire;
      (r.vw == VW_IDLE && r.smiDone && smiAct) |=> s_msgOut;
   endproperty
   a_smiFire: assert property (p_smiFire) else $error("smi not sent");

   property p_smiHold;
      $rose(smiMsgValid) |-> $past(r.smiDone) || $past(smiDoneSet);
   endproperty
   a_smiHold: assert property (p_smiHold) else $error("smi sent without flag");

   property p_smiResend;
      s_doneWrite |=> s_msgOut;
   endproperty
   a_smiResend: assert property (p_smiResend) else $error("smi not resent");

   property p_sciLevel;
      ##1 sciOut == ($past(sciAct) ^ $past(r.shared));
   endproperty
   a_sciLevel: assert property (p_sciLevel) else $error("sci level wrong");

   property p_legacyLine;
      rst_n && !r.apic |=> sciIrqNum inside {5'h09, 5'h0a, 5'h0b};
   endproperty
   a_legacyLine: assert property (p_legacyLine) else $error("bad legacy line");

   property p_apicLine;
      sciIrqNum inside {5'h00, 5'h09, 5'h0a, 5'h0b, 5'h14, 5'h15, 5'h16, 5'h17};
   endproperty
   a_apicLine: assert property (p_apicLine) else $error("bad apic line");

   property p_sticky;
      !(wr && paddr == OFS_STATUS) |=> (r.sts & $past(r.sts)) == $past(r.sts);
   endproperty
   a_sticky: assert property (p_sticky) else $error("status lost");

   property p_pcieNoSmi;
      ((r.sts & ~MASK_PCIE) == '0) |-> !smiAct;
   endproperty
   a_pcieNoSmi: assert property (p_pcieNoSmi) else $error("pcie caused smi");

   property p_intrSel;
      $rose(r.sts[SRC_INTRUDE]) |-> $past(r.intrSel) == INTR_SEL_SMI;
   endproperty
   a_intrSel: assert property (p_intrSel) else $error("intrusion unselected");

   property p_tmrWrap;
      tmrWrap |=> r.sts[SRC_TMR_WRAP] && r.tmr == 32'h0;
   endproperty
   a_tmrWrap: assert property (p_tmrWrap) else $error("wrap not flagged");

   property p_nmiPair;
      $rose(r.sts[SRC_NMI]) |-> r.sts[SRC_WD_SMI];
   endproperty
   a_nmiPair: assert property (p_nmiPair) else $error("nmi pair missing");

   // ------------------------------------------------------------
   // message link and source checks
   // ------------------------------------------------------------
   // the message stands until the processor takes it, then drops
   property p_smiStay;
      (smiMsgValid && !smiMsgReady) |=> smiMsgValid;
   endproperty
   a_smiStay: assert property (p_smiStay) else $error("smi message dropped early");

   property p_smiDrop;
      (smiMsgValid && smiMsgReady) |=> !smiMsgValid;
   endproperty
   a_smiDrop: assert property (p_smiDrop) else $error("smi message repeated");

   // with the done flag clear and no software set, nothing may leave
   property p_smiNoRefire;
      (!r.smiDone && !smiDoneSet && r.vw == VW_IDLE) |=> !smiMsgValid;
   endproperty
   a_smiNoRefire: assert property (p_smiNoRefire) else $error("smi without flag");

   property p_sciShared;
      (r.shared && !sciAct) |=> sciOut;
   endproperty
   a_sciShared: assert property (p_sciShared) else $error("shared sci not idle high");

   property p_sciPrivate;
      (!r.shared && sciAct) |=> sciOut;
   endproperty
   a_sciPrivate: assert property (p_sciPrivate) else $error("private sci not asserted");

   property p_wakeSts;
      extWakeIn |=> r.sts[SRC_EXT_WAKE];
   endproperty
   a_wakeSts: assert property (p_wakeSts) else $error("wake status missing");

   property p_ovrSts;
      buttonOverrideIn |=> r.sts[SRC_BTN_OVR];
   endproperty
   a_ovrSts: assert property (p_ovrSts) else $error("override status missing");

   property p_cpuSciSts;
      processorSciIn |=> r.sts[SRC_CPU_SCI];
   endproperty
   a_cpuSciSts: assert property (p_cpuSciSts) else $error("processor sci missing");

   property p_centurySts;
      centuryRollIn |=> r.sts[SRC_CENTURY];
   endproperty
   a_centurySts: assert property (p_centurySts) else $error("century status missing");

   property p_fwRelSts;
      (wr && paddr == OFS_CTRL && pwdata[CTL_FW_REL]) |=> r.sts[SRC_GLOBAL];
   endproperty
   a_fwRelSts: assert property (p_fwRelSts) else $error("global status missing");

   property p_pmPortSts;
      (wr && paddr == OFS_PM_PORT) |=> r.sts[SRC_PM_PORT];
   endproperty
   a_pmPortSts: assert property (p_pmPortSts) else $error("port status missing");

   property p_serIrqSts;
      serialIrqSmiIn |=> r.sts[SRC_SER_IRQ];
   endproperty
   a_serIrqSts: assert property (p_serIrqSts) else $error("serial irq missing");

   // a write of one clears a bit whose event is quiet in that cycle
   property p_clearBit;
      (wr && paddr == OFS_STATUS && pwdata[SRC_EXT_WAKE] && !extWakeIn)
         |=> !r.sts[SRC_EXT_WAKE];
   endproperty
   a_clearBit: assert property (p_clearBit) else $error("status not cleared");

endmodule : sser_top

// ---- rtl/sser_pkg.sv ----
package sser_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_ENABLE = 12'h004;
   localparam logic [11:0] OFS_CTRL = 12'h008;
   localparam logic [11:0] OFS_WD_DATA = 12'h00c;
   localparam logic [11:0] OFS_PM_PORT = 12'h010;

   // ------------------------------------------------------------
   // event sources: bit index in status and enable
   // ------------------------------------------------------------
   localparam int NSRC = 21;
   localparam int SRC_EXT_WAKE = 0;
   localparam int SRC_INT_WAKE = 1;
   localparam int SRC_PCIE_WAKE = 2;
   localparam int SRC_HOT_PLUG = 3;
   localparam int SRC_BTN_PRESS = 4;
   localparam int SRC_BTN_OVR = 5;
   localparam int SRC_TMR_WRAP = 6;
   localparam int SRC_CPU_SCI = 7;
   localparam int SRC_WD_SCI = 8;
   localparam int SRC_WD_SMI = 9;
   localparam int SRC_CENTURY = 10;
   localparam int SRC_WD_TMO = 11;
   localparam int SRC_OS_DATA = 12;
   localparam int SRC_NMI = 13;
   localparam int SRC_INTRUDE = 14;
   localparam int SRC_FW_WRITE = 15;
   localparam int SRC_GLOBAL = 16;
   localparam int SRC_FW_STS = 17;
   localparam int SRC_PM_PORT = 18;
   localparam int SRC_SER_IRQ = 19;
   localparam int SRC_DEV_TRAP = 20;

   // capability masks: SCI only, SMI only, either, no enable needed
   localparam logic [20:0] MASK_SCI_ONLY = 21'h0101ac;
   localparam logic [20:0] MASK_SMI_ONLY = 21'h1efe00;
   localparam logic [20:0] MASK_DUAL = 21'h000053;
   localparam logic [20:0] MASK_FIXED_EN = 21'h081ca0;
   localparam logic [20:0] MASK_GLOBAL = 21'h010000;
   localparam logic [20:0] MASK_PCIE = 21'h00000c;

   // ------------------------------------------------------------
   // control register fields and reset values
   // ------------------------------------------------------------
   localparam int CTL_ACPI_INT_GLOBAL_ENABLE = 0;
   localparam int CTL_SMI_DONE = 1;
   localparam int CTL_APIC = 2;
   localparam int CTL_IRQ_LSB = 4;
   localparam int CTL_SHARED = 7;
   localparam int CTL_INTR_LSB = 8;
   localparam int CTL_LOCK = 10;
   localparam int CTL_WPD = 11;
   localparam int CTL_FW_REL = 12;
   localparam int CTL_GBL_REL = 13;
   localparam logic [1:0] INTR_SEL_SMI = 2'h2;
   localparam logic [2:0] IRQ_SEL_MAX_LEGACY = 3'h2;
   localparam logic [4:0] IRQ_BASE_LEGACY = 5'h09;
   localparam logic [4:0] IRQ_BASE_APIC = 5'h11;
   localparam logic RST_SMI_DONE = 1'b1;

   // ------------------------------------------------------------
   // timing: pm timer wrap period
   // ------------------------------------------------------------
   localparam longint CLK_MHZ = 250;
   localparam longint TMR_WRAP_US = 2340000;
   localparam longint TMR_WRAP_CYC = TMR_WRAP_US * CLK_MHZ;

   typedef enum logic {VW_IDLE = 1'b0, VW_SEND = 1'b1} sser_vw_t;
endpackage : sser_pkg

// ---- sim/sser_host_model.sv ----
`timescale 1ns/10ps
// ----
// processor side of the smi message link
// ----
module sser_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic smiMsgValid,
   output logic smiMsgReady,
   output logic [7:0] msgCnt
);
   logic [2:0] waitCnt_r;
   logic slow_r;
   // alternate prompt and late acceptance so both paths get exercised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         smiMsgReady <= 1'b0;
         msgCnt <= 8'h00;
         waitCnt_r <= 3'h0;
         slow_r <= 1'b0;
      end else if (smiMsgValid && smiMsgReady) begin
         smiMsgReady <= 1'b0;
         msgCnt <= msgCnt + 8'h01;
         waitCnt_r <= 3'h0;
         slow_r <= !slow_r;
      end else if (smiMsgValid && waitCnt_r >= (slow_r ? 3'h5 : 3'h0)) begin
         smiMsgReady <= 1'b1;
      end else if (smiMsgValid) begin
         waitCnt_r <= waitCnt_r + 3'h1;
      end
   end
endmodule : sser_host_model

// ---- sim/sser_top_tb.sv ----
`timescale 1ns/10ps
module sser_top_tb import sser_pkg::*; ;
   // ----
   // stimulus and wiring
   // ----
   localparam int TW = 64;
   localparam logic [31:0] ALL = 32'h1fffff;
   localparam logic [31:0] EXP[15] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h20,
      32'h80, 32'h100, 32'h200, 32'h400, 32'h800, 32'h2200, 32'h8000, 32'h80000,
      32'h100000};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic intr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [14:0] ev = 15'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, smiMsgValid, smiMsgReady, sciOut;
   logic [4:0] sciIrqNum;
   logic [7:0] msgCnt, base;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   sser_top #(.TMR_WRAP(TW)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .extWakeIn(ev[0]),
      .intWakeIn(ev[1]), .pcieWakeMsgIn(ev[2]), .hotPlugMsgIn(ev[3]),
      .buttonPressIn(ev[4]), .buttonOverrideIn(ev[5]), .processorSciIn(ev[6]),
      .wdSciEventIn(ev[7]), .wdSmiEventIn(ev[8]), .centuryRollIn(ev[9]),
      .wdTimeoutIn(ev[10]), .nmiIn(ev[11]), .chassisIntrusionIn(intr),
      .fwWriteAttemptIn(ev[12]), .serialIrqSmiIn(ev[13]), .devTrapMatchIn(ev[14]),
      .smiMsgValid(smiMsgValid), .smiMsgReady(smiMsgReady), .sciOut(sciOut),
      .sciIrqNum(sciIrqNum));
   sser_host_model i_host (.clk(clk), .rst_n(rst_n), .smiMsgValid(smiMsgValid),
      .smiMsgReady(smiMsgReady), .msgCnt(msgCnt));
   // ----
   // tasks
   // ----
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask : pulse
   // settle, then wait a bounded time for the message count
   task automatic cnt(input logic [7:0] n);
      repeat (12) @(posedge clk);
      for (int k = 0; k < 30 && msgCnt !== n; k++) @(posedge clk);
      chk("msgCnt", 32'(n), 32'(msgCnt));
   endtask : cnt
   task automatic sci(input logic e);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("sciOut", 32'(e), 32'(sciOut));
   endtask : sci
   // ----
   // hang guard, well above the expected run of under a thousand cycles
   // ----
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test;
      end
   end
   // ----
   // test sequence
   // ----
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("irqNum", 32'd9, 32'(sciIrqNum));
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", 32'h2, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      apb(1'b1, OFS_ENABLE, 32'h1fffbf);
      // one source at a time, timer wrap bit masked off
      for (int i = 0; i < 15; i++) begin
         apb(1'b1, OFS_STATUS, ALL);
         pulse(i);
         apb(1'b0, OFS_STATUS, 32'h0);
         chk("status", EXP[i], rd & 32'h1fffbf);
      end
      repeat (TW + 4) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("wrap", 32'h40, rd & 32'h40);
      apb(1'b1, OFS_STATUS, ALL);
      apb(1'b1, OFS_CTRL, 32'h400);
      apb(1'b1, OFS_CTRL, 32'hc00);
      apb(1'b1, OFS_CTRL, 32'h1000);
      apb(1'b1, OFS_CTRL, 32'h2000);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("fwStatus", 32'h38000, rd & 32'h38000);
      // an os write to the watchdog data register is an smi source too
      apb(1'b1, OFS_WD_DATA, 32'h5a);
      apb(1'b0, OFS_WD_DATA, 32'h0);
      chk("wdData", 32'h5a, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("osData", 32'h1000, rd & 32'h1000);
      apb(1'b1, OFS_STATUS, ALL);
      apb(1'b1, OFS_CTRL, 32'h2);
      base = msgCnt;
      pulse(9);
      cnt(base + 8'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("doneFlag", 32'h0, rd & 32'h2);
      pulse(10);
      cnt(base + 8'h1);
      apb(1'b1, OFS_CTRL, 32'h2);
      cnt(base + 8'h2);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("sticky", 32'hc00, rd & 32'hc00);
      apb(1'b1, OFS_STATUS, ALL);
      apb(1'b1, OFS_CTRL, 32'h2);
      pulse(2);
      pulse(3);
      cnt(base + 8'h2);
      @(posedge clk);
      intr <= 1'b1;
      cnt(base + 8'h2);
      intr <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h202);
      @(posedge clk);
      intr <= 1'b1;
      cnt(base + 8'h3);
      intr <= 1'b0;
      apb(1'b1, OFS_STATUS, ALL);
      apb(1'b1, OFS_CTRL, 32'h2);
      apb(1'b1, OFS_PM_PORT, 32'h0);
      cnt(base + 8'h4);
      apb(1'b1, OFS_STATUS, ALL);
      apb(1'b1, OFS_CTRL, 32'h2);
      pulse(0);
      cnt(base + 8'h5);
      // sci level, polarity and release
      apb(1'b1, OFS_ENABLE, 32'h0);
      apb(1'b1, OFS_STATUS, ALL);
      apb(1'b1, OFS_CTRL, 32'h1);
      sci(1'b0);
      pulse(5);
      sci(1'b1);
      apb(1'b1, OFS_CTRL, 32'h81);
      sci(1'b0);
      apb(1'b1, OFS_STATUS, ALL);
      sci(1'b1);
      pulse(6);
      apb(1'b1, OFS_CTRL, 32'h1);
      sci(1'b1);
      apb(1'b1, OFS_STATUS, ALL);
      sci(1'b0);
      // with the global enable set a dual source goes to sci, never smi
      apb(1'b1, OFS_ENABLE, 32'h10);
      apb(1'b1, OFS_CTRL, 32'h3);
      pulse(4);
      sci(1'b1);
      cnt(base + 8'h5);
      apb(1'b1, OFS_STATUS, ALL);
      sci(1'b0);
      // line selection in both interrupt modes
      for (int a = 0; a < 2; a++) begin
         for (int s = 0; s < 7; s++) begin
            apb(1'b1, OFS_CTRL, {25'h0, 3'(s), 1'b0, 1'(a), 2'b01});
            @(posedge clk);
            @(negedge clk);
            chk("irqNum", 32'((s < 3) ? 9 + s : (a == 1 ? 17 + s : 9)),
               32'(sciIrqNum));
         end
      end
      stop_test;
   end
endmodule : sser_top_tb
